/* src/flash_command_sequencer.sv */
// Flash command sequencer: parameter words, launch, checks, status flags.
// Assumes software waits for the complete flag before touching parameters.
`timescale 1ns/1ps
`default_nettype none
module flash_command_sequencer #(
  parameter int ERASE_COUNT = flash_seq_pkg::ERASE_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdata,
  input  wire logic [63:0] storedKey,
  input  wire logic        verifyFail,
  input  wire logic        verifyUncorr,
  output logic      [1:0]  marginSel,
  output logic      [3:0]  marginLevel,
  output logic             secured,
  output logic             irq
);

  typedef flash_seq_pkg::seq_state_type st_type;
  // Every check below runs on the one clock and sleeps during reset.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  st_type        state_r, state_nxt;
  logic [2:0]    index_r, index_nxt;
  logic [15:0]   param_r [0:4];
  logic [15:0]   param_nxt [0:4];
  logic          complete_r, complete_nxt;
  flash_seq_pkg::err_flags_type err_r, err_nxt;
  logic [7:0]    security_r, security_nxt;
  logic          keyLock_r, keyLock_nxt;
  logic          unsecured_r, unsecured_nxt;
  logic [3:0]    protect_r, protect_nxt;
  logic          modeOk_r, modeOk_nxt;
  logic [1:0]    irqStat_r, irqStat_nxt;
  logic [1:0]    irqEn_r, irqEn_nxt;
  logic [1:0]    mSel_r, mSel_nxt;
  logic [3:0]    mLvl_r, mLvl_nxt;
  logic [15:0]   rdata_r, rdata_nxt;
  logic          engStart, engBusy, engDone;
  logic          launch;
  logic [7:0]    cmd;
  logic [1:0]    blk;
  logic [17:0]   addr;

  assign cmd  = param_r[0][15:8];
  assign blk  = param_r[0][1:0];
  assign addr = {blk, param_r[1]};
  // Launch is a write of one to the complete bit while idle.
  assign launch = regWrite && (regAddr == flash_seq_pkg::OFF_STATUS) &&
                  regWdata[flash_seq_pkg::STAT_COMPLETE_BIT] && complete_r;

  erase_engine #(
    .CYCLES (ERASE_COUNT)
  ) u_erase (
    .clock  (clock),
    .resetn (resetn),
    .start  (engStart),
    .busy   (engBusy),
    .done   (engDone)
  );

  // Sequencer and register next-state logic; an error never starts the
  // array, which keeps a bad command from erasing anything.
  always_comb
  begin
    state_nxt    = state_r;
    index_nxt    = index_r;
    param_nxt    = param_r;
    complete_nxt = complete_r;
    err_nxt      = err_r;
    security_nxt = security_r;
    keyLock_nxt  = keyLock_r;
    unsecured_nxt = unsecured_r;
    protect_nxt  = protect_r;
    modeOk_nxt   = modeOk_r;
    irqStat_nxt  = irqStat_r;
    irqEn_nxt    = irqEn_r;
    mSel_nxt     = mSel_r;
    mLvl_nxt     = mLvl_r;
    engStart     = 1'b0;
    if (regWrite && complete_r)
    begin
      if (regAddr == flash_seq_pkg::OFF_PARAM_INDEX)
        index_nxt = regWdata[2:0];
      else if (regAddr == flash_seq_pkg::OFF_PARAM_DATA && index_r < 3'h5)
        param_nxt[index_r] = regWdata;
      else if (regAddr == flash_seq_pkg::OFF_SECURITY)
        security_nxt = regWdata[7:0];
      else if (regAddr == flash_seq_pkg::OFF_PROTECT)
        protect_nxt = regWdata[3:0];
      else if (regAddr == flash_seq_pkg::OFF_MODE)
        modeOk_nxt = regWdata[0];
    end
    if (regWrite && regAddr == flash_seq_pkg::OFF_IRQ_ENABLE)
      irqEn_nxt = regWdata[1:0];
    if (regWrite && regAddr == flash_seq_pkg::OFF_IRQ_CLEAR)
      irqStat_nxt = irqStat_r & ~regWdata[1:0];
    case (state_r)
      flash_seq_pkg::ST_IDLE:
      begin
        if (launch)
        begin
          complete_nxt = 1'b0;
          err_nxt = '0;
          if (cmd == flash_seq_pkg::CMD_ERASE_BLOCK ||
              cmd == flash_seq_pkg::CMD_ERASE_SECTOR)
          begin
            if (index_r != flash_seq_pkg::LAST_IDX_ERASE || !modeOk_r ||
                blk >= flash_seq_pkg::BLOCK_LIMIT)
              err_nxt.accessError = 1'b1;
            else if ((blk == 2'h0 && addr[2:0] != 3'h0) ||
                     (blk != 2'h0 && addr[0]))
              err_nxt.accessError = 1'b1;
            else if (protect_r[blk])
              err_nxt.protectError = 1'b1;
            if (err_nxt == '0)
            begin
              engStart  = 1'b1;
              state_nxt = flash_seq_pkg::ST_ERASE;
            end
            else
              state_nxt = flash_seq_pkg::ST_DONE;
          end
          else if (cmd == flash_seq_pkg::CMD_VERIFY_KEY)
          begin
            if (index_r != flash_seq_pkg::LAST_IDX_KEY || keyLock_r ||
                security_r[7:6] != flash_seq_pkg::KEY_ENABLED)
            begin
              err_nxt.accessError = 1'b1;
              state_nxt = flash_seq_pkg::ST_DONE;
            end
            else
              state_nxt = flash_seq_pkg::ST_KEY;
          end
          else if (cmd == flash_seq_pkg::CMD_SET_MARGIN &&
                   index_r == flash_seq_pkg::LAST_IDX_MARGIN)
          begin
            mSel_nxt  = blk;
            mLvl_nxt  = param_r[1][3:0];
            state_nxt = flash_seq_pkg::ST_DONE;
          end
          else
          begin
            err_nxt.accessError = 1'b1;
            state_nxt = flash_seq_pkg::ST_DONE;
          end
        end
      end
      flash_seq_pkg::ST_ERASE:
        if (engDone)
          state_nxt = flash_seq_pkg::ST_VERIFY;
      flash_seq_pkg::ST_VERIFY:
      begin
        err_nxt.verifyError = verifyFail;
        err_nxt.uncorrError = verifyUncorr;
        state_nxt = flash_seq_pkg::ST_DONE;
      end
      flash_seq_pkg::ST_KEY:
      begin
        // Key 0 is the word stored at the base address, in the top lane.
        if ({param_r[1], param_r[2], param_r[3], param_r[4]} == storedKey)
          unsecured_nxt = 1'b1;
        else
        begin
          keyLock_nxt = 1'b1;
          err_nxt.accessError = 1'b1;
        end
        state_nxt = flash_seq_pkg::ST_DONE;
      end
      flash_seq_pkg::ST_DONE:
      begin
        complete_nxt = 1'b1;
        irqStat_nxt[flash_seq_pkg::IRQ_DONE_BIT] = 1'b1;
        if (err_r != '0)
          irqStat_nxt[flash_seq_pkg::IRQ_ERROR_BIT] = 1'b1;
        state_nxt = flash_seq_pkg::ST_IDLE;
      end
      default:
        state_nxt = flash_seq_pkg::ST_IDLE;
    endcase
  end

  // Read data multiplexer; unmapped offsets read zero.
  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (regRead)
    begin
      if (regAddr == flash_seq_pkg::OFF_PARAM_INDEX)
        rdata_nxt = {13'h0000, index_r};
      else if (regAddr == flash_seq_pkg::OFF_PARAM_DATA && index_r < 3'h5)
        rdata_nxt = param_r[index_r];
      else if (regAddr == flash_seq_pkg::OFF_STATUS)
        rdata_nxt = {8'h00, complete_r, 1'b0, err_r.accessError,
                     err_r.protectError, 2'h0, err_r.verifyError,
                     err_r.uncorrError};
      else if (regAddr == flash_seq_pkg::OFF_SECURITY)
        rdata_nxt = {8'h00, security_r};
      else if (regAddr == flash_seq_pkg::OFF_IRQ_STATUS)
        rdata_nxt = {14'h0000, irqStat_r};
      else if (regAddr == flash_seq_pkg::OFF_IRQ_ENABLE)
        rdata_nxt = {14'h0000, irqEn_r};
      else if (regAddr == flash_seq_pkg::OFF_MARGIN)
        rdata_nxt = {10'h000, mSel_r, mLvl_r};
      else if (regAddr == flash_seq_pkg::OFF_PROTECT)
        rdata_nxt = {12'h000, protect_r};
      else if (regAddr == flash_seq_pkg::OFF_MODE)
        rdata_nxt = {15'h0000, modeOk_r};
    end
  end

  // Registers only; the key lock survives everything but reset.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r     <= flash_seq_pkg::ST_IDLE;
      index_r     <= 3'h0;
      param_r     <= '{default: 16'h0000};
      complete_r  <= 1'b1;
      err_r       <= '0;
      security_r  <= flash_seq_pkg::SECURITY_RESET;
      keyLock_r   <= 1'b0;
      unsecured_r <= 1'b0;
      protect_r   <= flash_seq_pkg::PROTECT_RESET;
      modeOk_r    <= 1'b1;
      irqStat_r   <= 2'h0;
      irqEn_r     <= 2'h0;
      mSel_r      <= 2'h0;
      mLvl_r      <= 4'h0;
      rdata_r     <= 16'h0000;
    end
    else
    begin
      state_r     <= state_nxt;
      index_r     <= index_nxt;
      param_r     <= param_nxt;
      complete_r  <= complete_nxt;
      err_r       <= err_nxt;
      security_r  <= security_nxt;
      keyLock_r   <= keyLock_nxt;
      unsecured_r <= unsecured_nxt;
      protect_r   <= protect_nxt;
      modeOk_r    <= modeOk_nxt;
      irqStat_r   <= irqStat_nxt;
      irqEn_r     <= irqEn_nxt;
      mSel_r      <= mSel_nxt;
      mLvl_r      <= mLvl_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  assign regRdata    = rdata_r;
  assign marginSel   = mSel_r;
  assign marginLevel = mLvl_r;
  assign secured     = !unsecured_r;
  assign irq         = |(irqStat_r & irqEn_r);

  // Checks on the sequencer.
  property p_busy_low;
    (state_r != flash_seq_pkg::ST_IDLE) |-> !complete_r;
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("complete flag high while busy");
  property p_erase_verify;
    engDone |=> (state_r == flash_seq_pkg::ST_VERIFY) ##2 complete_r;
  endproperty
  a_erase_verify: assert property (p_erase_verify)
    else $error("erase did not verify and complete");
  property p_lock_abort;
    (launch && keyLock_r && cmd == flash_seq_pkg::CMD_VERIFY_KEY)
      |-> ##2 (complete_r && err_r.accessError && secured);
  endproperty
  a_lock_abort: assert property (p_lock_abort)
    else $error("locked key check not aborted");
  property p_key_done;
    (state_r == flash_seq_pkg::ST_KEY) |-> ##2 complete_r;
  endproperty
  a_key_done: assert property (p_key_done)
    else $error("key check did not complete");
  property p_bad_index;
    (launch && cmd == flash_seq_pkg::CMD_VERIFY_KEY &&
     index_r != flash_seq_pkg::LAST_IDX_KEY) |=> ##1 err_r.accessError;
  endproperty
  a_bad_index: assert property (p_bad_index)
    else $error("bad key index not flagged");
  property p_protect;
    (launch && cmd == flash_seq_pkg::CMD_ERASE_BLOCK &&
     err_nxt == 4'b0100) |=> (!engBusy) [*2];
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected block erased");
  property p_margin;
    (launch && cmd == flash_seq_pkg::CMD_SET_MARGIN &&
     index_r == flash_seq_pkg::LAST_IDX_MARGIN)
      |=> (marginLevel == $past(param_r[1][3:0]));
  endproperty
  a_margin: assert property (p_margin)
    else $error("margin level not applied");
  property p_verify;
    (state_r == flash_seq_pkg::ST_VERIFY && verifyFail)
      |=> err_r.verifyError;
  endproperty
  a_verify: assert property (p_verify)
    else $error("verify failure not flagged");
  c_erase: cover property (engDone ##2 complete_r);
  c_unlock: cover property ($fell(secured));
  c_lock: cover property ($rose(keyLock_r));

endmodule : flash_command_sequencer
`default_nettype wire

/* src/flash_seq_pkg.sv */
// Package for the flash command sequencer: register offsets, field positions,
// command codes, reset values and timing counts.
// Assumes a single 200 MHz clock domain and a plain strobe register port.
package flash_seq_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] OFF_PARAM_INDEX  = 4'h0;
  localparam logic [3:0] OFF_PARAM_DATA   = 4'h1;
  localparam logic [3:0] OFF_STATUS       = 4'h2;
  localparam logic [3:0] OFF_SECURITY     = 4'h3;
  localparam logic [3:0] OFF_IRQ_STATUS   = 4'h4;
  localparam logic [3:0] OFF_IRQ_CLEAR    = 4'h5;
  localparam logic [3:0] OFF_IRQ_ENABLE   = 4'h6;
  localparam logic [3:0] OFF_MARGIN       = 4'h7;
  localparam logic [3:0] OFF_PROTECT      = 4'h8;
  localparam logic [3:0] OFF_MODE         = 4'h9;

  // Status register bit positions.
  localparam int STAT_COMPLETE_BIT  = 7;
  localparam int STAT_ACCESS_BIT    = 5;
  localparam int STAT_PROTECT_BIT   = 4;
  localparam int STAT_VERIFY_BIT    = 1;
  localparam int STAT_UNCORR_BIT    = 0;

  // Interrupt status bit positions.
  localparam int IRQ_DONE_BIT       = 0;
  localparam int IRQ_ERROR_BIT      = 1;

  // Command codes in the upper byte of parameter word 0.
  localparam logic [7:0] CMD_ERASE_BLOCK  = 8'h09;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h0A;
  localparam logic [7:0] CMD_VERIFY_KEY   = 8'h0C;
  localparam logic [7:0] CMD_SET_MARGIN   = 8'h0D;

  // Last parameter index expected by each command.
  localparam logic [2:0] LAST_IDX_ERASE   = 3'h1;
  localparam logic [2:0] LAST_IDX_KEY     = 3'h4;
  localparam logic [2:0] LAST_IDX_MARGIN  = 3'h1;

  // Backdoor key enable value and stored key word base address.
  localparam logic [1:0]  KEY_ENABLED     = 2'h2;
  localparam logic [17:0] KEY_BASE_ADDR   = 18'h3FF00;

  // Reset values.
  localparam logic [7:0]  SECURITY_RESET  = 8'h00;
  localparam logic [3:0]  PROTECT_RESET   = 4'h0;

  // Number of valid blocks selected by address bits 17 to 16.
  localparam logic [1:0]  BLOCK_LIMIT     = 2'h2;

  // Erase time per block, in ns, and the derived count.
  localparam int ERASE_TIME_NS  = 1000;
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int ERASE_CYCLES   = ERASE_TIME_NS / CLOCK_PERIOD_NS;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ERASE  = 3'b001,
    ST_VERIFY = 3'b010,
    ST_KEY    = 3'b011,
    ST_DONE   = 3'b100
  } seq_state_type;

  // Result flags of one command.
  typedef struct packed {
    logic accessError;
    logic protectError;
    logic verifyError;
    logic uncorrError;
  } err_flags_type;

endpackage : flash_seq_pkg

/* src/erase_engine.sv */
// Erase timing engine for the flash command sequencer.
// Assumes a start pulse from the sequencer; the array's erase-verify result goes to the sequencer.
`timescale 1ns/1ps
`default_nettype none
module erase_engine #(
  parameter int CYCLES = flash_seq_pkg::ERASE_CYCLES
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic        busy_r;
  logic        busy_nxt;

  // Counts down the erase time; done is one cycle at the end.
  always_comb
  begin
    count_nxt = count_r;
    busy_nxt  = busy_r;
    if (start)
    begin
      count_nxt = 16'(CYCLES - 1);
      busy_nxt  = 1'b1;
    end
    else if (busy_r)
    begin
      if (count_r == 16'h0000)
        busy_nxt = 1'b0;
      else
        count_nxt = count_r - 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      count_r <= 16'h0000;
      busy_r  <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      busy_r  <= busy_nxt;
    end
  end

  assign busy = busy_r;
  assign done = busy_r && (count_r == 16'h0000);

endmodule : erase_engine
`default_nettype wire

/* dv/tb_flash_command_sequencer.sv */
// Self-checking testbench for the flash command sequencer.
// Assumes the sequencer's register map and a single 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_flash_command_sequencer;
  localparam int EraseCount = 4;

  logic        clock;
  logic        resetn;
  logic [3:0]  regAddr;
  logic [15:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [15:0] regRdata;
  logic [63:0] storedKey;
  logic        verifyFail;
  logic        verifyUncorr;
  logic [1:0]  marginSel;
  logic [3:0]  marginLevel;
  logic        secured;
  logic        irq;
  int          fail_count;
  int          compares;

  flash_command_sequencer #(.ERASE_COUNT(EraseCount)) uut (
    .clock(clock), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .storedKey(storedKey), .verifyFail(verifyFail),
    .verifyUncorr(verifyUncorr), .marginSel(marginSel),
    .marginLevel(marginLevel), .secured(secured), .irq(irq)
  );

  // The clock toggles every half period of 5 ns.
  always #2.5 clock = ~clock;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write strobe, taken at the next rising edge; a quiet cycle
  // follows so that two calls never drive the strobe twice in one step.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    @(posedge clock);
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 v = regRdata;
    @(posedge clock);
  endtask : rd

  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rdc

  task automatic doReset();
    resetn <= 1'b0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
  endtask : doReset

  // Loads n words, sets the final index, launches and waits under a bound.
  task automatic cmd(input logic [15:0] w [0:4], input int n,
                     input logic [2:0] lastIdx, input bit busyChk,
                     input logic [15:0] expStat);
    logic [15:0] v;
    int          k;
    for (int i = 0; i < n; i++)
    begin
      wr(4'h0, 16'(i));
      wr(4'h1, w[i]);
    end
    wr(4'h0, {13'h0000, lastIdx});
    wr(4'h2, 16'h0080);
    rd(4'h2, v);
    if (busyChk)
      chk({15'h0000, v[7]}, 16'h0000);
    k = 0;
    while (v[7] !== 1'b1 && k < 40)
    begin
      rd(4'h2, v);
      k++;
    end
    chk(v, expStat);
  endtask : cmd

  // Two-word command: word 0 and word 1, then the given final index.
  task automatic cmd2(input logic [15:0] w0, input logic [15:0] w1,
                      input logic [2:0] lastIdx, input bit busyChk,
                      input logic [15:0] expStat);
    logic [15:0] w [0:4];
    w = '{w0, w1, 16'h0000, 16'h0000, 16'h0000};
    cmd(w, 2, lastIdx, busyChk, expStat);
  endtask : cmd2

  task automatic test_reset();
    rdc(4'h2, 16'h0080);
    rdc(4'h7, 16'h0000);
    rdc(4'hF, 16'h0000);
    chk({14'h0000, secured, irq}, 16'h0002);
    $display("test reset done");
  endtask : test_reset

  // Good erases of both blocks, with the done interrupt raised and cleared.
  task automatic test_erase_ok();
    wr(4'h5, 16'h0003);
    wr(4'h6, 16'h0001);
    cmd2(16'h0900, 16'h0008, 3'h1, 1'b1, 16'h0080);
    rdc(4'h4, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    wr(4'h5, 16'h0001);
    @(posedge clock);
    chk({15'h0000, irq}, 16'h0000);
    cmd2(16'h0901, 16'h0002, 3'h1, 1'b1, 16'h0080);
    wr(4'h6, 16'h0000);
    @(posedge clock);
    chk({15'h0000, irq}, 16'h0000);
    $display("test erase ok done");
  endtask : test_erase_ok

  task automatic test_erase_err();
    cmd2(16'h0900, 16'h0000, 3'h0, 1'b0, 16'h00A0);
    cmd2(16'h0902, 16'h0000, 3'h1, 1'b0, 16'h00A0);
    cmd2(16'h0900, 16'h0004, 3'h1, 1'b0, 16'h00A0);
    cmd2(16'h0901, 16'h0001, 3'h1, 1'b0, 16'h00A0);
    // An unknown command code is refused as an access error.
    cmd2(16'h0500, 16'h0000, 3'h1, 1'b0, 16'h00A0);
    rdc(4'h4, 16'h0003);
    // The error interrupt alone raises the line once it is enabled.
    wr(4'h6, 16'h0002);
    @(posedge clock);
    chk({15'h0000, irq}, 16'h0001);
    wr(4'h6, 16'h0000);
    wr(4'h9, 16'h0000);
    cmd2(16'h0900, 16'h0000, 3'h1, 1'b0, 16'h00A0);
    wr(4'h9, 16'h0001);
    wr(4'h8, 16'h0002);
    cmd2(16'h0901, 16'h0000, 3'h1, 1'b0, 16'h0090);
    cmd2(16'h0A00, 16'h0000, 3'h1, 1'b1, 16'h0080);
    wr(4'h8, 16'h0000);
    $display("test erase errors done");
  endtask : test_erase_err

  // Verify faults reported by the array during sector and block erase.
  task automatic test_verify();
    verifyFail <= 1'b1;
    cmd2(16'h0A01, 16'h1234, 3'h1, 1'b1, 16'h0082);
    verifyUncorr <= 1'b1;
    cmd2(16'h0900, 16'h0000, 3'h1, 1'b1, 16'h0083);
    verifyFail   <= 1'b0;
    verifyUncorr <= 1'b0;
    $display("test verify done");
  endtask : test_verify

  task automatic test_key_ok();
    logic [15:0] w [0:4];
    w = '{16'h0C00, storedKey[63:48], storedKey[47:32], storedKey[31:16],
          storedKey[15:0]};
    cmd(w, 5, 3'h4, 1'b0, 16'h00A0);
    chk({15'h0000, secured}, 16'h0001);
    wr(4'h3, 16'h0080);
    cmd(w, 5, 3'h3, 1'b0, 16'h00A0);
    cmd(w, 5, 3'h4, 1'b0, 16'h0080);
    chk({15'h0000, secured}, 16'h0000);
    $display("test key ok done");
  endtask : test_key_ok

  // A mismatch locks the check even for the right key until reset.
  task automatic test_key_bad();
    logic [15:0] w [0:4];
    doReset();
    w = '{16'h0C00, storedKey[63:48], storedKey[47:32], storedKey[31:16],
          storedKey[15:0] ^ 16'h0001};
    wr(4'h3, 16'h0080);
    cmd(w, 5, 3'h4, 1'b0, 16'h00A0);
    chk({15'h0000, secured}, 16'h0001);
    w[4] = storedKey[15:0];
    cmd(w, 5, 3'h4, 1'b0, 16'h00A0);
    chk({15'h0000, secured}, 16'h0001);
    $display("test key lock done");
  endtask : test_key_bad

  task automatic test_margin();
    // A margin command with the wrong final index flags an access error and leaves the margin unchanged.
    cmd2(16'h0D01, 16'h0003, 3'h0, 1'b0, 16'h00A0);
    chk({10'h000, marginSel, marginLevel}, 16'h0000);
    cmd2(16'h0D01, 16'h0005, 3'h1, 1'b0, 16'h0080);
    chk({10'h000, marginSel, marginLevel}, 16'h0015);
    rdc(4'h7, 16'h0015);
    cmd2(16'h0D02, 16'h000A, 3'h1, 1'b0, 16'h0080);
    chk({10'h000, marginSel, marginLevel}, 16'h002A);
    $display("test margin done");
  endtask : test_margin

  task automatic end_sim();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // Main sequence; all inputs have a value at time zero.
  initial
  begin
    clock        = 1'b0;
    resetn       = 1'b0;
    regAddr      = 4'h0;
    regWdata     = 16'h0000;
    regWrite     = 1'b0;
    regRead      = 1'b0;
    storedKey    = 64'h1234_5678_9ABC_DEF0;
    verifyFail   = 1'b0;
    verifyUncorr = 1'b0;
    fail_count   = 0;
    compares     = 0;
    doReset();
    test_reset();
    test_erase_ok();
    test_erase_err();
    test_verify();
    test_key_ok();
    test_key_bad();
    test_margin();
    end_sim();
  end

  // The tests need a few hundred cycles; this bound is far beyond that.
  initial
  begin
    #200000;
    fail_count++;
    end_sim();
  end
endmodule : tb_flash_command_sequencer
`default_nettype wire
